/* File: tvw_threshold_bank.sv */
// Temperature and supply warning threshold bank with warning flag generation
//
// Behaviour
// - Temperature above high threshold sets warning
// - Temperature below low threshold sets warning
// - Supply above high threshold sets warning
// - Supply below low threshold sets warning
// - Lower threshold bytes stored, never compared
// - Temperature threshold pairs, one degree upper step
// - Supply upper step 25.6mV, compared directly
// - Supply pair lower step 100 microvolts
// - Compare raw codes, no calibration applied
`timescale 1ns/10ps
`default_nettype none
module tvw_threshold_bank (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  clkEnable,
	input  wire tvw_pkg::tvw_addr_type regAddr,
	input  wire logic                  regWrite,
	input  wire tvw_pkg::tvw_byte_type regWriteData,
	input  wire logic                  regRead,
	output tvw_pkg::tvw_byte_type      regReadData,
	output logic                       regReadValid,
	input  wire logic                  measStore,
	input  wire tvw_pkg::tvw_byte_type measTempUpper,
	input  wire tvw_pkg::tvw_byte_type measSupplyUpper,
	output logic                       warnTempHigh,
	output logic                       warnTempLow,
	output logic                       warnSupplyHigh,
	output logic                       warnSupplyLow
);
	import tvw_pkg::*;

	tvw_thresh_if  thrBus ();

	tvw_byte_type  bankReadData;
	logic [3:0]    cmpFlags;

	tvw_state_type state;
	tvw_state_type next_state;
	tvw_byte_type  tempLatched;
	tvw_byte_type  next_tempLatched;
	tvw_byte_type  supplyLatched;
	tvw_byte_type  next_supplyLatched;
	logic [3:0]    flags;
	logic [3:0]    next_flags;
	tvw_byte_type  next_regReadData;
	logic          next_regReadValid;

	// Threshold storage; lower bytes kept only so software can read them back
	tvw_reg_file bank (
		.clk       (clk),
		.reset_n   (reset_n),
		.clkEnable (clkEnable),
		.writeEn   (regWrite),
		.addr      (regAddr),
		.writeData (regWriteData),
		.readData  (bankReadData),
		.thr       (thrBus)
	);

	// Comparators see the latched measurement, not the live converter bus
	tvw_compare cmp (
		.thr         (thrBus),
		.tempUpper   (tempLatched),
		.supplyUpper (supplyLatched),
		.flags       (cmpFlags)
	);

	// Latch a new measurement, then refresh the flags one cycle later
	always_comb begin
		next_state         = state;
		next_tempLatched   = tempLatched;
		next_supplyLatched = supplyLatched;
		next_flags         = flags;
		unique case (state)
			ST_IDLE: begin
				if (measStore) begin
					next_tempLatched   = measTempUpper;
					next_supplyLatched = measSupplyUpper;
					next_state         = ST_EVAL;
				end
			end
			ST_EVAL: begin
				next_flags = cmpFlags;
				if (measStore) begin
					// Back-to-back stores chain without dropping a sample
					next_tempLatched   = measTempUpper;
					next_supplyLatched = measSupplyUpper;
					next_state         = ST_EVAL;
				end else begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state         <= ST_IDLE;
			tempLatched   <= THRESH_RESET;
			supplyLatched <= THRESH_RESET;
			flags         <= FLAGS_RESET;
		end else if (clkEnable) begin
			state         <= next_state;
			tempLatched   <= next_tempLatched;
			supplyLatched <= next_supplyLatched;
			flags         <= next_flags;
		end
	end

	// Read answer is registered so the serial slave samples a stable byte
	always_comb begin
		next_regReadValid = regRead;
		next_regReadData  = regRead ? bankReadData : regReadData;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regReadData  <= READ_UNMAPPED;
			regReadValid <= 1'b0;
		end else if (clkEnable) begin
			regReadData  <= next_regReadData;
			regReadValid <= next_regReadValid;
		end
	end

	// Flags are levels: they follow the latest evaluation in both directions
	assign warnTempHigh   = flags[FLAG_TEMP_HIGH];
	assign warnTempLow    = flags[FLAG_TEMP_LOW];
	assign warnSupplyHigh = flags[FLAG_SUPPLY_HIGH];
	assign warnSupplyLow  = flags[FLAG_SUPPLY_LOW];
endmodule
`default_nettype wire

/* File: tvw_pkg.sv */
// Shared constants, types and decode helpers for the warning threshold bank
package tvw_pkg;

	typedef logic [7:0]  tvw_byte_type;
	typedef logic [7:0]  tvw_addr_type;
	typedef logic [15:0] tvw_word_type;
	typedef logic [2:0]  tvw_index_type;

	// Byte addresses of the threshold registers on the serial register port
	localparam tvw_addr_type OFS_TEMP_HIGH_UPPER   = 8'h04;
	localparam tvw_addr_type OFS_TEMP_HIGH_LOWER   = 8'h05;
	localparam tvw_addr_type OFS_TEMP_LOW_UPPER    = 8'h06;
	localparam tvw_addr_type OFS_TEMP_LOW_LOWER    = 8'h07;
	localparam tvw_addr_type OFS_SUPPLY_HIGH_UPPER = 8'h0c;
	localparam tvw_addr_type OFS_SUPPLY_HIGH_LOWER = 8'h0d;
	localparam tvw_addr_type OFS_SUPPLY_LOW_UPPER  = 8'h0e;
	localparam tvw_addr_type OFS_SUPPLY_LOW_LOWER  = 8'h0f;

	// Storage slots inside the bank
	localparam int NUM_REGS = 8;
	localparam tvw_index_type IDX_TEMP_HIGH_UPPER   = 3'h0;
	localparam tvw_index_type IDX_TEMP_HIGH_LOWER   = 3'h1;
	localparam tvw_index_type IDX_TEMP_LOW_UPPER    = 3'h2;
	localparam tvw_index_type IDX_TEMP_LOW_LOWER    = 3'h3;
	localparam tvw_index_type IDX_SUPPLY_HIGH_UPPER = 3'h4;
	localparam tvw_index_type IDX_SUPPLY_HIGH_LOWER = 3'h5;
	localparam tvw_index_type IDX_SUPPLY_LOW_UPPER  = 3'h6;
	localparam tvw_index_type IDX_SUPPLY_LOW_LOWER  = 3'h7;

	// Reset and unmapped read values
	localparam tvw_byte_type THRESH_RESET  = 8'h00;
	localparam tvw_byte_type READ_UNMAPPED = 8'h00;

	// Code weights of the threshold bytes, documentation only for software
	localparam int TEMP_UPPER_STEP_DEGC  = 1;
	localparam int SUPPLY_UPPER_STEP_UV  = 25600;
	localparam int SUPPLY_LOWER_STEP_UV  = 100;

	// Warning flag positions
	localparam int NUM_FLAGS          = 4;
	localparam int FLAG_TEMP_HIGH     = 0;
	localparam int FLAG_TEMP_LOW      = 1;
	localparam int FLAG_SUPPLY_HIGH   = 2;
	localparam int FLAG_SUPPLY_LOW    = 3;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Evaluation sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EVAL = 2'b10
	} tvw_state_type;

	// Address decode used for both writes and reads: {hit, slot}
	function automatic logic [3:0] decode_offset(input tvw_addr_type addr);
		logic [3:0] result;
		result = {1'b0, IDX_TEMP_HIGH_UPPER};
		case (addr)
			OFS_TEMP_HIGH_UPPER:   result = {1'b1, IDX_TEMP_HIGH_UPPER};
			OFS_TEMP_HIGH_LOWER:   result = {1'b1, IDX_TEMP_HIGH_LOWER};
			OFS_TEMP_LOW_UPPER:    result = {1'b1, IDX_TEMP_LOW_UPPER};
			OFS_TEMP_LOW_LOWER:    result = {1'b1, IDX_TEMP_LOW_LOWER};
			OFS_SUPPLY_HIGH_UPPER: result = {1'b1, IDX_SUPPLY_HIGH_UPPER};
			OFS_SUPPLY_HIGH_LOWER: result = {1'b1, IDX_SUPPLY_HIGH_LOWER};
			OFS_SUPPLY_LOW_UPPER:  result = {1'b1, IDX_SUPPLY_LOW_UPPER};
			OFS_SUPPLY_LOW_LOWER:  result = {1'b1, IDX_SUPPLY_LOW_LOWER};
			default:               result = {1'b0, IDX_TEMP_HIGH_UPPER};
		endcase
		return result;
	endfunction

	// Joins an upper and lower threshold byte into one sixteen-bit code
	function automatic tvw_word_type pair_bytes(input tvw_byte_type upper,
		input tvw_byte_type lower);
		return {upper, lower};
	endfunction

endpackage

/* File: tvw_thresh_if.sv */
// Carrier for the sixteen-bit threshold pairs between bank and comparators
`timescale 1ns/10ps
`default_nettype none
interface tvw_thresh_if;
	logic [15:0] tempHigh;
	logic [15:0] tempLow;
	logic [15:0] supplyHigh;
	logic [15:0] supplyLow;

	modport bank (output tempHigh, output tempLow, output supplyHigh, output supplyLow);
	modport cmp  (input tempHigh, input tempLow, input supplyHigh, input supplyLow);
endinterface
`default_nettype wire

/* File: tvw_reg_file.sv */
// Threshold byte storage with write port and combinational read port
`timescale 1ns/10ps
`default_nettype none
module tvw_reg_file (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          clkEnable,
	input  wire logic          writeEn,
	input  wire tvw_pkg::tvw_addr_type addr,
	input  wire tvw_pkg::tvw_byte_type writeData,
	output tvw_pkg::tvw_byte_type      readData,
	tvw_thresh_if.bank         thr
);
	import tvw_pkg::*;

	tvw_byte_type regBank      [NUM_REGS];
	tvw_byte_type next_regBank [NUM_REGS];
	logic [3:0]   decoded;

	assign decoded = decode_offset(addr);

	// Every byte, lower halves included, stores and reads back as written
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			next_regBank[i] = regBank[i];
		end
		if (writeEn && decoded[3]) begin
			next_regBank[decoded[2:0]] = writeData;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_REGS; i++) begin
			if (!reset_n) begin
				regBank[i] <= THRESH_RESET;
			end else if (clkEnable) begin
				regBank[i] <= next_regBank[i];
			end
		end
	end

	// Unmapped offsets read as zero rather than aliasing a slot
	assign readData = decoded[3] ? regBank[decoded[2:0]] : READ_UNMAPPED;

	// Upper and lower bytes travel as one sixteen-bit pair
	assign thr.tempHigh   = pair_bytes(regBank[IDX_TEMP_HIGH_UPPER],
		regBank[IDX_TEMP_HIGH_LOWER]);
	assign thr.tempLow    = pair_bytes(regBank[IDX_TEMP_LOW_UPPER],
		regBank[IDX_TEMP_LOW_LOWER]);
	assign thr.supplyHigh = pair_bytes(regBank[IDX_SUPPLY_HIGH_UPPER],
		regBank[IDX_SUPPLY_HIGH_LOWER]);
	assign thr.supplyLow  = pair_bytes(regBank[IDX_SUPPLY_LOW_UPPER],
		regBank[IDX_SUPPLY_LOW_LOWER]);
endmodule
`default_nettype wire

/* File: tvw_compare.sv */
// Raw upper-byte comparators that produce the four warning conditions
`timescale 1ns/10ps
`default_nettype none
module tvw_compare (
	tvw_thresh_if.cmp                  thr,
	input  wire tvw_pkg::tvw_byte_type tempUpper,
	input  wire tvw_pkg::tvw_byte_type supplyUpper,
	output logic [3:0]                 flags
);
	import tvw_pkg::*;

	// Only bits 15:8 of each pair matter; the measurement carries only an upper byte
	always_comb begin
		flags                   = FLAGS_RESET;
		flags[FLAG_TEMP_HIGH]   = tempUpper   > thr.tempHigh[15:8];
		flags[FLAG_TEMP_LOW]    = tempUpper   < thr.tempLow[15:8];
		flags[FLAG_SUPPLY_HIGH] = supplyUpper > thr.supplyHigh[15:8];
		flags[FLAG_SUPPLY_LOW]  = supplyUpper < thr.supplyLow[15:8];
	end
endmodule
`default_nettype wire

/* File: tvw_threshold_bank_sva.sv */
// Port checker for the warning threshold bank
`timescale 1ns/10ps
`default_nettype none
module tvw_threshold_bank_sva (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  clkEnable,
	input wire tvw_pkg::tvw_addr_type regAddr,
	input wire logic                  regWrite,
	input wire tvw_pkg::tvw_byte_type regWriteData,
	input wire logic                  regRead,
	input wire tvw_pkg::tvw_byte_type regReadData,
	input wire logic                  regReadValid,
	input wire logic                  measStore,
	input wire tvw_pkg::tvw_byte_type measTempUpper,
	input wire tvw_pkg::tvw_byte_type measSupplyUpper,
	input wire logic                  warnTempHigh,
	input wire logic                  warnTempLow,
	input wire logic                  warnSupplyHigh,
	input wire logic                  warnSupplyLow
);
	import tvw_pkg::*;
	logic [7:0] th [4];
	logic [7:0] next_th [4];
	logic       upHit;
	logic [7:0] upVal;
	// Shadow of the upper bytes only, since lower bytes never reach the flags
	assign upHit = !regAddr[0] && (regAddr[7:2] == 6'h01 || regAddr[7:2] == 6'h03);
	assign upVal = th[{regAddr[3], regAddr[1]}];
	always_comb begin
		next_th = th;
		if (regWrite && upHit)
			next_th[{regAddr[3], regAddr[1]}] = regWriteData;
	end
	always_ff @(posedge clk) begin
		if (!reset_n)
			th <= '{default: 8'h00};
		else if (clkEnable)
			th <= next_th;
	end
	// A frozen clock enable stretches every latency, so those cycles are not judged
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n || !clkEnable);
	// Thresholds are those in force at the evaluation edge, one after the store
	temp_high_a: assert property (measStore |-> ##2 warnTempHigh == ($past(measTempUpper, 2) > $past(th[0])))
		else $error("temp high flag wrong");
	temp_low_a: assert property (measStore |-> ##2 warnTempLow == ($past(measTempUpper, 2) < $past(th[1])))
		else $error("temp low flag wrong");
	supply_high_a: assert property (measStore |-> ##2 warnSupplyHigh == ($past(measSupplyUpper, 2) > $past(th[2])))
		else $error("supply high flag wrong");
	supply_low_a: assert property (measStore |-> ##2 warnSupplyLow == ($past(measSupplyUpper, 2) < $past(th[3])))
		else $error("supply low flag wrong");
	flags_hold_a: assert property (!$past(measStore, 2) |-> $stable({warnTempHigh, warnTempLow, warnSupplyHigh, warnSupplyLow}))
		else $error("flags moved without a sample");
	upper_readback_a: assert property (regRead && upHit |=> regReadData == $past(upVal))
		else $error("upper byte read wrong");
	read_answer_a: assert property (regRead |=> regReadValid)
		else $error("read answer missing");
	read_pulse_a: assert property (!regRead |=> !regReadValid)
		else $error("read answer without a read");
	unmapped_read_a: assert property (regRead && !(regAddr inside {[8'h04:8'h07], [8'h0c:8'h0f]}) |=> regReadData == 8'h00)
		else $error("unmapped read not zero");
	cover property (measStore ##2 warnTempHigh);
	cover property (measStore ##2 warnSupplyLow);
	cover property (regRead && regAddr == 8'h08 ##1 regReadValid);
endmodule
bind tvw_threshold_bank tvw_threshold_bank_sva sva (.*);
`default_nettype wire

/* File: tvw_host.sv */
// Host model driving the threshold register port
`timescale 1ns/10ps
`default_nettype none
module tvw_host (
	input  wire logic             clk,
	output tvw_pkg::tvw_addr_type regAddr,
	output tvw_pkg::tvw_byte_type regWriteData,
	output logic                  regWrite,
	output logic                  regRead
);
	import tvw_pkg::*;
	initial begin
		regAddr = 8'h00;
		regWriteData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// One strobe per access; afterwards the bus is inverted so stale values never look valid
	task automatic xfer(input logic w, input tvw_addr_type a, input tvw_byte_type d);
		@(negedge clk);
		regAddr = a;
		regWriteData = d;
		regWrite = w;
		regRead = !w;
		@(negedge clk);
		regAddr = ~a;
		regWriteData = ~d;
		regWrite = 1'b0;
		regRead = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tvw_threshold_bank_test.sv */
// Self-checking bench for the warning threshold bank
`timescale 1ns/10ps
`default_nettype none
module tvw_threshold_bank_test;
	import tvw_pkg::*;
	logic         clk = 1'b0;
	logic         reset_n = 1'b0;
	logic         measStore = 1'b0;
	logic         clkEn = 1'b1;
	logic         wr, rd, rdValid;
	wire   [3:0]  flags;
	logic  [1:0]  mp = 2'h0;
	logic  [31:0] seed = 32'h24;
	tvw_addr_type regAddr;
	tvw_byte_type wrData, rdData;
	tvw_byte_type t = 8'h00;
	tvw_byte_type s = 8'h00;
	tvw_byte_type thr [4];
	tvw_byte_type rq [$];
	logic  [3:0]  fq [$];
	int           n_errors = 0;
	int           comparisons = 0;
	int           cycles = 0;
	always #12.5 clk = ~clk;
	tvw_host host (.clk(clk), .regAddr(regAddr), .regWriteData(wrData), .regWrite(wr), .regRead(rd));
	tvw_threshold_bank dut (.clk(clk), .reset_n(reset_n), .clkEnable(clkEn), .regAddr(regAddr),
		.regWrite(wr), .regWriteData(wrData), .regRead(rd), .regReadData(rdData),
		.regReadValid(rdValid), .measStore(measStore), .measTempUpper(t), .measSupplyUpper(s),
		.warnTempHigh(flags[0]), .warnTempLow(flags[1]), .warnSupplyHigh(flags[2]),
		.warnSupplyLow(flags[3]));
	function automatic tvw_byte_type rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Slots 0..7 map to 04..07 and 0c..0f
	function automatic tvw_addr_type adr(input int i);
		return {4'h0, i[2], 1'b1, i[1:0]};
	endfunction
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] v);
		comparisons++;
		if (v !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic rd_reg(input tvw_addr_type a, input tvw_byte_type e);
		rq.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask
	// Expected flags are worked out from the bench's own copy of the upper bytes
	task automatic meas(input tvw_byte_type tv, input tvw_byte_type sv);
		fq.push_back({sv < thr[3], sv > thr[2], tv < thr[1], tv > thr[0]});
		t = tv;
		s = sv;
		measStore = 1'b1;
		@(negedge clk);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Tracks when a sample's flags become due: evaluated one edge after the store
	always @(posedge clk) begin
		cycles <= cycles + 1;
		mp <= {mp[0], measStore};
	end
	// Results are taken half a cycle after their edge, where they have settled
	always @(negedge clk) begin
		if (rdValid === 1'b1) check("read", rq.pop_front(), rdData);
		if (mp[1]) check("flags", {4'h0, fq.pop_front()}, {4'h0, flags});
		if (cycles == 2000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		int i;
		tvw_byte_type d;
		tvw_byte_type bt [4];
		tvw_byte_type bs [4];
		bt = '{8'h1f, 8'h20, 8'h50, 8'h51};
		bs = '{8'h5f, 8'h60, 8'h90, 8'h91};
		thr = '{8'h50, 8'h20, 8'h90, 8'h60};
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		// Reset contents, then an unmapped place that must keep reading zero
		for (i = 0; i < 8; i++) rd_reg(adr(i), 8'h00);
		host.xfer(1'b1, 8'h08, 8'hff);
		rd_reg(8'h08, 8'h00);
		$display("reset and map test done");
		for (i = 0; i < 8; i++) host.xfer(1'b1, adr(i), i[0] ? 8'h00 : thr[i / 2]);
		// A write strobe while the clock enable is low must not land
		clkEn = 1'b0;
		host.xfer(1'b1, adr(0), 8'hff);
		clkEn = 1'b1;
		for (i = 0; i < 8; i++) rd_reg(adr(i), i[0] ? 8'h00 : thr[i / 2]);
		for (i = 0; i < 4; i++) meas(bt[i], bs[3 - i]);
		for (i = 0; i < 24; i++) meas(rnd(), rnd());
		measStore = 1'b0;
		$display("threshold test done");
		// Lower bytes take any value, yet the same samples give the same flags
		for (i = 1; i < 8; i += 2) begin
			d = rnd();
			host.xfer(1'b1, adr(i), d);
			rd_reg(adr(i), d);
		end
		for (i = 0; i < 4; i++) meas(bt[i], bs[3 - i]);
		measStore = 1'b0;
		$display("lower byte test done");
		repeat (4) @(negedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire
